// [tlq_defs.vh]
// constants for the transaction-layer queue, ordering and flow-control core
// assumes one 32-bit dword per beat on both the receive and transmit streams
`ifndef TLQ_DEFS_VH
`define TLQ_DEFS_VH

`define TLQ_FMT_DATA 30
`define TLQ_FMT_4DW 29
`define TLQ_TYPE_HI 28
`define TLQ_TYPE_LO 24
`define TLQ_TC_HI 22
`define TLQ_TC_LO 20
`define TLQ_ATTR_RO 13
`define TLQ_LEN_HI 9

`define TLQ_TYPE_MEM 5'h00
`define TLQ_TYPE_IO 5'h02
`define TLQ_TYPE_CFG0 5'h04
`define TLQ_TYPE_CFG1 5'h05
`define TLQ_TYPE_CPL 5'h0a
`define TLQ_TYPE_CPLLK 5'h0b
`define TLQ_MSG_TOP 2'h2

`define TLQ_PH_W 128
`define TLQ_NONPOSTED_HEADER_DATA_QUEUE_W 160
`define TLQ_CPLH_W 96
`define TLQ_STAMP_W 8
`define TLQ_CPL_BYTES 12'h004

`define TLQ_REFRESH_NS 30000
`define TLQ_CLK_NS 40
`define TLQ_REFRESH_CYC (`TLQ_REFRESH_NS / `TLQ_CLK_NS)

`endif

// [ordered_queue.v]
// first-in first-out queue with look-ahead read data and a free-entry count
// assumes the user never pushes when full nor pops when empty
`timescale 1ns/1ps
module ordered_queue #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
)(
  input wire core_clk,
  input wire nrst,
  input wire push,
  input wire [WIDTH-1:0] wdata,
  input wire pop,
  output wire [WIDTH-1:0] rdata,
  output wire empty,
  output wire [11:0] free
);
  localparam [11:0] DEPTH12 = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] cnt;

  assign rdata = mem[rd_ptr];
  assign empty = (cnt == {(AW+1){1'b0}});
  // free entries only, so advertised credit never runs ahead of space
  assign free = DEPTH12 - {{(11-AW){1'b0}}, cnt};

  always @(posedge core_clk) begin
    if (push)
      mem[wr_ptr] <= wdata;
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end
endmodule // ordered_queue

// [credit_refresh.v]
// paces credit-update requests to the link layer
// assumes changed is a same-clock level that is high while credits differ
`timescale 1ns/1ps
`include "tlq_defs.vh"
module credit_refresh #(
  parameter CYCLES = `TLQ_REFRESH_CYC
)(
  input wire core_clk,
  input wire nrst,
  input wire changed,
  output reg update
);
  reg [15:0] timer;
  wire expired = (timer == CYCLES - 1);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer <= 16'h0000;
      update <= 1'b0;
    end else begin
      // a fresh update restarts the keep-alive interval
      update <= changed | expired;
      if (changed || expired)
        timer <= 16'h0000;
      else
        timer <= timer + 16'h0001;
    end
  end
endmodule // credit_refresh

// [pcie_tl_queue_ordering_flow.v]
// transaction-layer core of one port: receive queues, ordering, credits, transmit
// assumes the link layer on the same clock, one dword per beat, header first
`timescale 1ns/1ps
`include "tlq_defs.vh"
module pcie_tl_queue_ordering_flow #(
  parameter P_DEPTH = 8,
  parameter P_AW = 3,
  parameter NP_DEPTH = 8,
  parameter NP_AW = 3,
  parameter C_DEPTH = 8,
  parameter C_AW = 3,
  parameter PD_DEPTH = 64,
  parameter PD_AW = 6,
  parameter CD_DEPTH = 64,
  parameter CD_AW = 6,
  parameter IS_UPSTREAM = 1,
  // arbitrary value
  parameter [15:0] COMPLETER_ID = 16'h0100,
  parameter REFRESH_CYC = `TLQ_REFRESH_CYC
)(
  input wire core_clk,
  input wire nrst,
  input wire rx_valid,
  input wire rx_sop,
  input wire rx_eop,
  input wire [31:0] rx_data,
  output reg rx_ready,
  output reg tx_valid,
  output reg tx_sop,
  output reg tx_eop,
  output reg [31:0] tx_data,
  input wire tx_ready,
  input wire [7:0] fc_ph_lim,
  input wire [11:0] fc_pd_lim,
  input wire [7:0] fc_nph_lim,
  input wire [11:0] fc_npd_lim,
  input wire [7:0] fc_cplh_lim,
  input wire [11:0] fc_cpld_lim,
  output reg [7:0] adv_ph,
  output reg [11:0] adv_pd,
  output reg [7:0] adv_nph,
  output reg [11:0] adv_npd,
  output reg [7:0] adv_cplh,
  output reg [11:0] adv_cpld,
  output wire fc_update,
  output reg cfg_req,
  output reg cfg_wr,
  output reg [9:0] cfg_addr,
  output reg [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata
);
  localparam K_P = 2'h0;
  localparam K_NP = 2'h1;
  localparam K_C = 2'h2;
  localparam K_DROP = 2'h3;
  localparam ST_IDLE = 3'b001;
  localparam ST_HDR = 3'b010;
  localparam ST_DATA = 3'b100;
  localparam SRC_PD = 2'h0;
  localparam SRC_CD = 2'h1;
  localparam SRC_INL = 2'h2;
  localparam NPE_W = `TLQ_NONPOSTED_HEADER_DATA_QUEUE_W + `TLQ_STAMP_W;
  localparam CE_W = `TLQ_CPLH_W + `TLQ_STAMP_W;

  integer i;

  function [11:0] dcred;
    input [9:0] len;
    reg [10:0] sum;
    begin
      sum = {1'b0, len} + 11'h003;
      dcred = (len == 10'h000) ? 12'h100 : {3'h0, sum[10:2]};
    end
  endfunction

  // ingress assembly
  reg [159:0] in_hdr;
  reg [2:0] in_cnt;
  reg [1:0] in_kind;
  reg in_h4;
  reg [1:0] dec_kind;
  reg [159:0] next_hdr;
  reg [`TLQ_STAMP_W-1:0] posted_in [0:7];
  reg [`TLQ_STAMP_W-1:0] posted_out [0:7];

  wire beat = rx_valid & rx_ready;
  wire [4:0] dec_type = rx_data[`TLQ_TYPE_HI:`TLQ_TYPE_LO];
  wire [1:0] cur_kind = rx_sop ? dec_kind : in_kind;
  wire cur_h4 = rx_sop ? rx_data[`TLQ_FMT_4DW] : in_h4;
  wire [2:0] cur_cnt = rx_sop ? 3'h0 : in_cnt;
  wire [2:0] hlen = cur_h4 ? 3'h4 : 3'h3;
  wire in_pay = (cur_cnt >= hlen);
  wire [2:0] tc_in = next_hdr[`TLQ_TC_HI:`TLQ_TC_LO];

  // every class is dispatched to the single channel's queues
  always @* begin
    if (dec_type[4:3] == `TLQ_MSG_TOP)
      dec_kind = (IS_UPSTREAM != 0) ? K_P : K_DROP;
    else if (dec_type == `TLQ_TYPE_MEM)
      dec_kind = rx_data[`TLQ_FMT_DATA] ? K_P : K_NP;
    else if (dec_type == `TLQ_TYPE_IO || dec_type == `TLQ_TYPE_CFG0 || dec_type == `TLQ_TYPE_CFG1)
      dec_kind = K_NP;
    else if (dec_type == `TLQ_TYPE_CPL || dec_type == `TLQ_TYPE_CPLLK)
      dec_kind = K_C;
    else
      dec_kind = K_DROP;
  end

  // non-posted data dword lands right after its header in the same entry
  always @* begin
    next_hdr = rx_sop ? 160'h0 : in_hdr;
    if (!in_pay || (cur_kind == K_NP && cur_cnt < 3'h5))
      next_hdr[cur_cnt*32 +: 32] = rx_data;
  end

  wire push_ph = beat && rx_eop && cur_kind == K_P;
  wire push_np = beat && rx_eop && cur_kind == K_NP;
  wire push_ch = beat && rx_eop && cur_kind == K_C;
  wire push_pd = beat && in_pay && cur_kind == K_P;
  wire push_cd = beat && in_pay && cur_kind == K_C;

  // queue heads
  wire [`TLQ_PH_W-1:0] ph_h;
  wire [NPE_W-1:0] np_e;
  wire [CE_W-1:0] c_e;
  wire [31:0] pd_rdata;
  wire [31:0] cd_rdata;
  wire ph_empty, np_empty, ch_empty, pd_empty, cd_empty;
  wire [11:0] ph_free, np_free, ch_free, pd_free, cd_free;
  wire pop_ph, pop_np, pop_ch, pop_pd, pop_cd;

  ordered_queue #(.WIDTH(`TLQ_PH_W), .DEPTH(P_DEPTH), .AW(P_AW)) u_ph_q (
    .core_clk(core_clk), .nrst(nrst), .push(push_ph), .wdata(next_hdr[`TLQ_PH_W-1:0]),
    .pop(pop_ph), .rdata(ph_h), .empty(ph_empty), .free(ph_free));
  ordered_queue #(.WIDTH(NPE_W), .DEPTH(NP_DEPTH), .AW(NP_AW)) u_np_q (
    .core_clk(core_clk), .nrst(nrst), .push(push_np), .wdata({posted_in[tc_in], next_hdr}),
    .pop(pop_np), .rdata(np_e), .empty(np_empty), .free(np_free));
  ordered_queue #(.WIDTH(CE_W), .DEPTH(C_DEPTH), .AW(C_AW)) u_ch_q (
    .core_clk(core_clk), .nrst(nrst), .push(push_ch),
    .wdata({posted_in[tc_in], next_hdr[`TLQ_CPLH_W-1:0]}),
    .pop(pop_ch), .rdata(c_e), .empty(ch_empty), .free(ch_free));
  ordered_queue #(.WIDTH(32), .DEPTH(PD_DEPTH), .AW(PD_AW)) u_pd_q (
    .core_clk(core_clk), .nrst(nrst), .push(push_pd), .wdata(rx_data),
    .pop(pop_pd), .rdata(pd_rdata), .empty(pd_empty), .free(pd_free));
  ordered_queue #(.WIDTH(32), .DEPTH(CD_DEPTH), .AW(CD_AW)) u_cd_q (
    .core_clk(core_clk), .nrst(nrst), .push(push_cd), .wdata(rx_data),
    .pop(pop_cd), .rdata(cd_rdata), .empty(cd_empty), .free(cd_free));

  // partner credit still available; limits arrive from the egress receiver
  reg [7:0] used_ph, used_nph, used_cplh;
  reg [11:0] used_pd, used_npd, used_cpld;
  wire [7:0] av_ph = fc_ph_lim - used_ph;
  wire [11:0] av_pd = fc_pd_lim - used_pd;
  wire [7:0] av_nph = fc_nph_lim - used_nph;
  wire [11:0] av_npd = fc_npd_lim - used_npd;
  wire [7:0] av_cplh = fc_cplh_lim - used_cplh;
  wire [11:0] av_cpld = fc_cpld_lim - used_cpld;

  // posted candidate
  wire p_data = ph_h[`TLQ_FMT_DATA];
  wire [2:0] p_tc = ph_h[`TLQ_TC_HI:`TLQ_TC_LO];
  wire [11:0] p_need = p_data ? dcred(ph_h[`TLQ_LEN_HI:0]) : 12'h000;
  wire p_ok = !ph_empty && av_ph != 8'h00 && av_pd >= p_need;

  // non-posted candidate
  wire [159:0] np_h = np_e[159:0];
  wire [`TLQ_STAMP_W-1:0] np_stamp = np_e[NPE_W-1:160];
  wire np_data = np_h[`TLQ_FMT_DATA];
  wire np_h4 = np_h[`TLQ_FMT_4DW];
  wire [2:0] np_tc = np_h[`TLQ_TC_HI:`TLQ_TC_LO];
  wire np_local = np_h[`TLQ_TYPE_HI:`TLQ_TYPE_LO] == `TLQ_TYPE_CFG0;
  wire [31:0] np_dw = np_h4 ? np_h[159:128] : np_h[127:96];
  wire np_fwd_cr = av_nph != 8'h00 && (!np_data || av_npd != 12'h000);
  wire np_loc_cr = av_cplh != 8'h00 && (np_data || av_cpld != 12'h000);
  wire np_ok = !np_empty && posted_out[np_tc] == np_stamp && (np_local ? np_loc_cr : np_fwd_cr);

  // completion candidate: only a read completion without relaxed order waits
  wire [95:0] c_h = c_e[95:0];
  wire [`TLQ_STAMP_W-1:0] c_stamp = c_e[CE_W-1:96];
  wire c_data = c_h[`TLQ_FMT_DATA];
  wire [2:0] c_tc = c_h[`TLQ_TC_HI:`TLQ_TC_LO];
  wire c_ro = c_h[`TLQ_ATTR_RO];
  wire [11:0] c_need = c_data ? dcred(c_h[`TLQ_LEN_HI:0]) : 12'h000;
  wire c_order = !c_data || c_ro || posted_out[c_tc] == c_stamp;
  wire c_ok = !ch_empty && c_order && av_cplh != 8'h00 && av_cpld >= c_need;

  // egress
  reg [2:0] state;
  reg last_p;
  reg [127:0] out_hdr;
  reg [2:0] out_hlen;
  reg [10:0] out_dlen;
  reg [10:0] out_idx;
  reg [1:0] out_src;
  reg [31:0] out_inline;

  wire slot_free = !tx_valid || tx_ready;
  wire go = state == ST_IDLE && slot_free;
  // posted gets every other turn when both sides wait, so neither starves
  wire take_p = go && p_ok && (!(c_ok || np_ok) || !last_p);
  wire take_c = go && !take_p && c_ok;
  wire take_np = go && !take_p && !c_ok && np_ok;
  wire dstep = state == ST_DATA && slot_free;

  assign pop_ph = take_p;
  assign pop_ch = take_c;
  assign pop_np = take_np;
  assign pop_pd = dstep && out_src == SRC_PD;
  assign pop_cd = dstep && out_src == SRC_CD;

  // completion for a local configuration access
  wire [31:0] lc_dw0 = {1'b0, !np_data, 1'b0, `TLQ_TYPE_CPL, 1'b0, np_tc, 4'h0,
                        2'h0, np_h[13:12], 2'h0, 9'h000, !np_data};
  wire [31:0] lc_dw1 = {COMPLETER_ID, 3'h0, 1'b0, `TLQ_CPL_BYTES};
  wire [31:0] lc_dw2 = {np_h[63:40], 8'h00};

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_hdr <= 160'h0;
      in_cnt <= 3'h0;
      in_kind <= K_DROP;
      in_h4 <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        posted_in[i] <= {`TLQ_STAMP_W{1'b0}};
        posted_out[i] <= {`TLQ_STAMP_W{1'b0}};
      end
    end else begin
      if (beat) begin
        in_hdr <= next_hdr;
        in_kind <= cur_kind;
        in_h4 <= cur_h4;
        in_cnt <= (cur_cnt == 3'h7) ? 3'h7 : cur_cnt + 3'h1;
      end
      // stamps per class let later requests wait only on their own class
      if (push_ph)
        posted_in[tc_in] <= posted_in[tc_in] + 1'b1;
      if (take_p)
        posted_out[p_tc] <= posted_out[p_tc] + 1'b1;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      last_p <= 1'b0;
      out_hdr <= 128'h0;
      out_hlen <= 3'h3;
      out_dlen <= 11'h000;
      out_idx <= 11'h000;
      out_src <= SRC_PD;
      out_inline <= 32'h0;
      tx_valid <= 1'b0;
      tx_sop <= 1'b0;
      tx_eop <= 1'b0;
      tx_data <= 32'h0;
      cfg_req <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_addr <= 10'h000;
      cfg_wdata <= 32'h0;
      used_ph <= 8'h00;
      used_pd <= 12'h000;
      used_nph <= 8'h00;
      used_npd <= 12'h000;
      used_cplh <= 8'h00;
      used_cpld <= 12'h000;
    end else begin
      cfg_req <= 1'b0;
      // local registers answer while the request is high
      if (cfg_req && !cfg_wr)
        out_inline <= cfg_rdata;
      case (state)
        ST_IDLE: begin
          if (slot_free)
            tx_valid <= 1'b0;
          out_idx <= 11'h000;
          if (take_p) begin
            last_p <= 1'b1;
            out_hdr <= ph_h;
            out_hlen <= ph_h[`TLQ_FMT_4DW] ? 3'h4 : 3'h3;
            out_dlen <= p_data ? {ph_h[`TLQ_LEN_HI:0] == 10'h000, ph_h[`TLQ_LEN_HI:0]} : 11'h000;
            out_src <= SRC_PD;
            used_ph <= used_ph + 8'h01;
            used_pd <= used_pd + p_need;
            state <= ST_HDR;
          end else if (take_c) begin
            last_p <= 1'b0;
            out_hdr <= {32'h0, c_h};
            out_hlen <= 3'h3;
            out_dlen <= c_data ? {c_h[`TLQ_LEN_HI:0] == 10'h000, c_h[`TLQ_LEN_HI:0]} : 11'h000;
            out_src <= SRC_CD;
            used_cplh <= used_cplh + 8'h01;
            used_cpld <= used_cpld + c_need;
            state <= ST_HDR;
          end else if (take_np) begin
            last_p <= 1'b0;
            out_src <= SRC_INL;
            state <= ST_HDR;
            if (np_local) begin
              out_hdr <= {32'h0, lc_dw2, lc_dw1, lc_dw0};
              out_hlen <= 3'h3;
              out_dlen <= {10'h000, !np_data};
              cfg_req <= 1'b1;
              cfg_wr <= np_data;
              cfg_addr <= np_h[75:66];
              cfg_wdata <= np_dw;
              used_cplh <= used_cplh + 8'h01;
              used_cpld <= used_cpld + {11'h000, !np_data};
            end else begin
              out_hdr <= np_h[127:0];
              out_hlen <= np_h4 ? 3'h4 : 3'h3;
              out_dlen <= {10'h000, np_data};
              out_inline <= np_dw;
              used_nph <= used_nph + 8'h01;
              used_npd <= used_npd + {11'h000, np_data};
            end
          end
        end
        ST_HDR: begin
          if (slot_free) begin
            tx_valid <= 1'b1;
            tx_sop <= out_idx == 11'h000;
            tx_data <= out_hdr[out_idx[1:0]*32 +: 32];
            tx_eop <= out_idx[2:0] == out_hlen - 3'h1 && out_dlen == 11'h000;
            if (out_idx[2:0] == out_hlen - 3'h1) begin
              out_idx <= 11'h000;
              state <= (out_dlen == 11'h000) ? ST_IDLE : ST_DATA;
            end else begin
              out_idx <= out_idx + 11'h001;
            end
          end
        end
        ST_DATA: begin
          if (slot_free) begin
            tx_valid <= 1'b1;
            tx_sop <= 1'b0;
            tx_data <= (out_src == SRC_PD) ? pd_rdata : (out_src == SRC_CD) ? cd_rdata : out_inline;
            tx_eop <= out_idx == out_dlen - 11'h001;
            out_idx <= out_idx + 11'h001;
            if (out_idx == out_dlen - 11'h001)
              state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // advertised credit: header entries one each, posted and completion data in units of four dwords, non-posted data one per entry
  wire [7:0] next_adv_ph = ph_free[7:0];
  wire [11:0] next_adv_pd = {2'h0, pd_free[11:2]};
  wire [7:0] next_adv_nph = np_free[7:0];
  wire [11:0] next_adv_npd = np_free;
  wire [7:0] next_adv_cplh = ch_free[7:0];
  wire [11:0] next_adv_cpld = {2'h0, cd_free[11:2]};
  wire adv_changed = next_adv_ph != adv_ph || next_adv_pd != adv_pd || next_adv_nph != adv_nph ||
                     next_adv_npd != adv_npd || next_adv_cplh != adv_cplh || next_adv_cpld != adv_cpld;
  // two free entries keep the registered ready one beat ahead of a push
  wire next_ready = ph_free > 12'h001 && np_free > 12'h001 && ch_free > 12'h001 &&
                    pd_free > 12'h001 && cd_free > 12'h001;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_ready <= 1'b0;
      adv_ph <= 8'h00;
      adv_pd <= 12'h000;
      adv_nph <= 8'h00;
      adv_npd <= 12'h000;
      adv_cplh <= 8'h00;
      adv_cpld <= 12'h000;
    end else begin
      rx_ready <= next_ready;
      adv_ph <= next_adv_ph;
      adv_pd <= next_adv_pd;
      adv_nph <= next_adv_nph;
      adv_npd <= next_adv_npd;
      adv_cplh <= next_adv_cplh;
      adv_cpld <= next_adv_cpld;
    end
  end

  credit_refresh #(.CYCLES(REFRESH_CYC)) u_refresh (
    .core_clk(core_clk),
    .nrst(nrst),
    .changed(adv_changed),
    .update(fc_update)
  );
endmodule // pcie_tl_queue_ordering_flow

// [tlq_properties.sv]
// concurrent checks on the transmit stream, credit outputs and local config strobe
// assumes one clock, asynchronous active-low reset, bound to the core's top module
`timescale 1ns/1ps
`include "tlq_defs.vh"
module tlq_properties #(
  parameter P_DEPTH = 8,
  parameter NP_DEPTH = 8,
  parameter C_DEPTH = 8,
  parameter PD_DEPTH = 64,
  parameter CD_DEPTH = 64,
  parameter REFRESH_CYC = `TLQ_REFRESH_CYC
)(
  input wire core_clk,
  input wire nrst,
  input wire tx_valid,
  input wire tx_sop,
  input wire tx_eop,
  input wire [31:0] tx_data,
  input wire tx_ready,
  input wire [7:0] adv_ph,
  input wire [11:0] adv_pd,
  input wire [7:0] adv_nph,
  input wire [11:0] adv_npd,
  input wire [7:0] adv_cplh,
  input wire [11:0] adv_cpld,
  input wire fc_update,
  input wire cfg_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  reg [15:0] idle_cnt;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) idle_cnt <= 16'h0000;
    else if (fc_update) idle_cnt <= 16'h0000;
    else idle_cnt <= idle_cnt + 16'h0001;
  end
  adv_update_a: assert property (!$stable({adv_ph, adv_pd, adv_nph, adv_npd, adv_cplh, adv_cpld}) |-> fc_update)
    else $error("credit change not followed by an update pulse");
  refresh_gap_a: assert property (idle_cnt < REFRESH_CYC)
    else $error("credit update interval too long");
  adv_limit_a: assert property (adv_ph <= P_DEPTH && adv_nph <= NP_DEPTH && adv_npd <= NP_DEPTH &&
    adv_cplh <= C_DEPTH && adv_pd <= PD_DEPTH / 4 && adv_cpld <= CD_DEPTH / 4)
    else $error("advertised credit above queue size");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_sop, tx_eop, tx_data}))
    else $error("transmit beat changed while stalled");
  tx_start_a: assert property ($rose(tx_valid) |-> tx_sop)
    else $error("packet started without start mark");
  tlp_gap_a: assert property (tx_valid && tx_ready && tx_eop |=> !tx_valid)
    else $error("no idle cycle after packet end");
  cfg_pulse_a: assert property (cfg_req |=> !cfg_req)
    else $error("config strobe longer than one cycle");
  cfg_cpl_a: assert property (cfg_req |=> tx_valid && tx_sop && tx_data[`TLQ_TYPE_HI:`TLQ_TYPE_LO] == `TLQ_TYPE_CPL)
    else $error("config access without completion start");
  cover property (cfg_req);
  cover property (tx_valid && !tx_ready);
  cover property (fc_update && $stable(adv_ph));
endmodule // tlq_properties

bind pcie_tl_queue_ordering_flow tlq_properties #(.P_DEPTH(P_DEPTH), .NP_DEPTH(NP_DEPTH), .C_DEPTH(C_DEPTH),
  .PD_DEPTH(PD_DEPTH), .CD_DEPTH(CD_DEPTH), .REFRESH_CYC(REFRESH_CYC)) u_tlq_properties (
  .core_clk(core_clk), .nrst(nrst), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
  .tx_data(tx_data), .tx_ready(tx_ready), .adv_ph(adv_ph), .adv_pd(adv_pd), .adv_nph(adv_nph),
  .adv_npd(adv_npd), .adv_cplh(adv_cplh), .adv_cpld(adv_cpld), .fc_update(fc_update), .cfg_req(cfg_req));

// [link_partner.sv]
// far-end model: accepts transmit beats, records them, grants credit limits
// assumes the core's clock; ready toggles when stalled so both fast and slow answers occur
`timescale 1ns/1ps
module link_partner (
  input wire core_clk,
  input wire nrst,
  input wire tx_valid,
  input wire tx_sop,
  input wire [31:0] tx_data,
  output reg tx_ready,
  output wire [7:0] hdr_lim,
  output wire [11:0] dat_lim,
  input wire stall,
  input wire hold_credit
);
  reg [31:0] beats [0:63];
  integer n_beat;
  reg [7:0] n_pkt;
  // a hold caps every limit at the packet count, so only a class that used all of it stops
  assign hdr_lim = hold_credit ? n_pkt : 8'h40;
  assign dat_lim = hold_credit ? {4'h0, n_pkt} : 12'h400;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      n_beat <= 0;
      n_pkt <= 8'h00;
    end else begin
      tx_ready <= !stall || !tx_ready;
      if (tx_valid && tx_ready && tx_sop)
        n_pkt <= n_pkt + 8'h01;
      if (tx_valid && tx_ready) begin
        beats[n_beat % 64] <= tx_data;
        n_beat <= n_beat + 1;
      end
    end
  end
endmodule // link_partner

// [tb.sv]
// self-checking bench for the transaction-layer queue, ordering and credit core
// assumes the partner model on the transmit side and a fixed local register value
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, nrst = 0, rx_valid = 0, rx_sop = 0, rx_eop = 0, stall = 0, hold_credit = 0;
  logic [31:0] rx_data = 32'h0, cfg_rdata = 32'h5a5a1234, last_wdata;
  logic [9:0] last_addr;
  logic last_wr;
  wire rx_ready, tx_valid, tx_sop, tx_eop, tx_ready, fc_update, cfg_req, cfg_wr;
  wire [31:0] tx_data, cfg_wdata;
  wire [9:0] cfg_addr;
  wire [7:0] adv_ph, adv_nph, adv_cplh, hdr_lim;
  wire [11:0] adv_pd, adv_npd, adv_cpld, dat_lim;
  integer fails = 0, n_tests = 0, cfg_hits = 0, b;
  always #20 core_clk = ~core_clk;
  pcie_tl_queue_ordering_flow #(.REFRESH_CYC(20)) u_pcie_tl_queue_ordering_flow (
    .core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
    .tx_data(tx_data), .tx_ready(tx_ready), .fc_ph_lim(hdr_lim), .fc_pd_lim(dat_lim), .fc_nph_lim(hdr_lim),
    .fc_npd_lim(dat_lim), .fc_cplh_lim(hdr_lim), .fc_cpld_lim(dat_lim), .adv_ph(adv_ph), .adv_pd(adv_pd),
    .adv_nph(adv_nph), .adv_npd(adv_npd), .adv_cplh(adv_cplh), .adv_cpld(adv_cpld), .fc_update(fc_update),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  link_partner u_link_partner (.core_clk(core_clk), .nrst(nrst), .tx_valid(tx_valid), .tx_sop(tx_sop),
    .tx_data(tx_data),
    .tx_ready(tx_ready), .hdr_lim(hdr_lim), .dat_lim(dat_lim), .stall(stall), .hold_credit(hold_credit));
  always @(negedge core_clk) begin
    if (cfg_req === 1'b1) begin
      cfg_hits = cfg_hits + 1;
      last_wr = cfg_wr;
      last_addr = cfg_addr;
      last_wdata = cfg_wdata;
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails = fails + 1;
    end
  endtask
  task hang(input string what);
    $display("Error %s expected done seen timeout", what);
    fails = fails + 1;
    print_verdict;
  endtask
  // ready is a register, so its value at the falling edge is what the next rising edge samples
  task beat(input logic [31:0] d, input logic s, input logic e);
    integer k;
    rx_valid = 1;
    rx_sop = s;
    rx_eop = e;
    rx_data = d;
    k = 0;
    while (rx_ready !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k = k + 1;
    end
    if (k == 100) hang("rx_ready");
    @(negedge core_clk);
  endtask
  task send(input logic [31:0] h0, h1, h2, h3, input logic four, input logic has, input logic [31:0] pl);
    beat(h0, 1, 0);
    beat(h1, 0, 0);
    beat(h2, 0, !four && !has);
    if (four) beat(h3, 0, !has);
    if (has) beat(pl, 0, 1);
    rx_valid = 0;
    @(negedge core_clk);
  endtask
  task wait_beats(input integer t);
    integer k;
    k = 0;
    while (u_link_partner.n_beat < t && k < 300) begin
      @(negedge core_clk);
      k = k + 1;
    end
    if (k == 300) hang("transmit beats");
  endtask
  function integer pos(input logic [31:0] v);
    integer i;
    pos = 99;
    for (i = b + 15; i >= b; i = i - 1) if (u_link_partner.beats[i] === v) pos = i;
  endfunction
  task t_reset;
    @(negedge core_clk);
    chk("fc_update", 1, 32'(fc_update));
    chk("rx_ready", 1, 32'(rx_ready));
    chk("adv_ph", 8, 32'(adv_ph));
    chk("adv_pd", 16, 32'(adv_pd));
    chk("adv_nph", 8, 32'(adv_nph));
    chk("adv_npd", 8, 32'(adv_npd));
    chk("adv_cplh", 8, 32'(adv_cplh));
    chk("adv_cpld", 16, 32'(adv_cpld));
    @(negedge core_clk);
    chk("fc_update settled", 0, 32'(fc_update));
    $display("test reset done");
  endtask
  task t_credit;
    hold_credit = 1;
    b = u_link_partner.n_beat;
    send(32'h40000001, 32'h0, 32'h00000100, 32'h0, 0, 1, 32'h000000a5);
    repeat (30) @(negedge core_clk);
    chk("gated beats", b, 32'(u_link_partner.n_beat));
    hold_credit = 0;
    wait_beats(b + 4);
    chk("released header", 32'h40000001, u_link_partner.beats[b]);
    $display("test credit done");
  endtask
  task t_order;
    // after the earlier write posted has no unit left and the other classes one each, so only ordering holds back read and completion
    hold_credit = 1;
    stall = 1;
    b = u_link_partner.n_beat;
    send(32'h40000001, 32'h0, 32'h00000200, 32'h0, 0, 1, 32'h00000011);
    send(32'h00000001, 32'h0, 32'h00000200, 32'h0, 0, 0, 32'h0);
    send(32'h60000001, 32'h0, 32'h0, 32'h00000300, 1, 1, 32'h00000022);
    send(32'h4a000001, 32'h0, 32'h0, 32'h0, 0, 1, 32'h00000033);
    repeat (10) @(negedge core_clk);
    chk("held behind posted", b, 32'(u_link_partner.n_beat));
    hold_credit = 0;
    wait_beats(b + 16);
    stall = 0;
    chk("posted order", 1, 32'(pos(32'h40000001) < pos(32'h60000001)));
    chk("read after write", 1, 32'(pos(32'h40000001) < pos(32'h00000001)));
    chk("cpl after writes", 1, 32'(pos(32'h60000001) < pos(32'h4a000001)));
    chk("posted data", 32'h11, u_link_partner.beats[pos(32'h40000001) + 3]);
    chk("cpl data", 32'h33, u_link_partner.beats[pos(32'h4a000001) + 3]);
    $display("test order done");
  endtask
  task t_cfg(input logic wr);
    integer h;
    h = cfg_hits;
    b = u_link_partner.n_beat;
    send(wr ? 32'h44000001 : 32'h04000001, 32'h0, 32'h00000028, 32'h0, 0, wr, 32'h000000c3);
    wait_beats(b + (wr ? 3 : 4));
    chk("cfg_req", h + 1, cfg_hits);
    chk("cfg_wr", 32'(wr), 32'(last_wr));
    chk("cfg_addr", 32'h00a, 32'(last_addr));
    if (wr) chk("cfg_wdata", 32'h000000c3, last_wdata);
    chk("cpl type", wr ? 32'h0a : 32'h4a, 32'(u_link_partner.beats[b][30:24]));
    if (!wr) chk("cpl read data", cfg_rdata, u_link_partner.beats[b + 3]);
    $display("test config done");
  endtask
  task t_refresh;
    integer cnt;
    repeat (40) @(negedge core_clk);
    cnt = 0;
    repeat (80) begin
      @(negedge core_clk);
      if (fc_update === 1'b1) cnt = cnt + 1;
    end
    chk("refresh pulses", 4, 32'(cnt));
    $display("test refresh done");
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1;
    t_reset;
    t_credit;
    t_order;
    t_cfg(1);
    t_cfg(0);
    t_refresh;
    print_verdict;
  end
endmodule // tb
